// ==== rtl/pbc_core.sv ====
// Core sequencing: banked data memory, core registers, program counter
// and interrupt entry and exit with shadow context.
// Assumes one fetch strobe per instruction and flag event pulses from
// logic on the same clock.
//
// Functional notes
// - Data memory is 32 banks of 128 bytes.
// - Active bank comes from bank select; software writes it.
// - Unimplemented data locations read zero.
// - Addresses are 12 bits: five bank bits, seven offset bits.
// - Every location reachable directly or through either pointer.
// - Core registers appear at the first 12 offsets of every bank.
// - Counter is 15 bits; low byte is a register, high from latch.
// - Whole counter clears on reset.
// - Writing counter low byte loads high bits from latch together.
// - Call takes operand for bits 10:0, latch 6:3 for 14:11.
// - Computed call: low byte from W, high from latch.
// - W branch: address plus one plus unsigned W.
// - Operand branch: address plus one plus signed operand bits 8:0.
// - All interrupts disabled after reset.
// - Vector needs global, own, and peripheral enable where used.
// - Flags set on events whatever the enables.
// - Entry flushes, clears global, pushes, shadows, jumps 0004h.
// - Global clear only records; pending served when set again.
// - Return pops, restores shadows, sets global enable.
// - Vector reached within three to five instruction cycles.
`timescale 1ns/1ps
module pbc_core (
  input wire logic core_clk_i, // 200 MHz core clock
  input wire logic reset_i, // Asynchronous reset, active high
  input wire logic fetch_i, // One pulse per instruction fetch
  input wire pbc_pkg::pbc_cmd_t cmd_i, // Sequencing command
  input wire pbc_pkg::pbc_dreq_t dreq_i, // Data access request
  input wire logic [7:0] status_i, // Status value from the ALU
  input wire logic status_we_i, // ALU status update strobe
  input wire logic [2:0] core_evt_i, // Core source event pulses
  input wire logic [7:0] periph_evt_i, // Peripheral event pulses
  input wire logic [14:0] stack_top_i, // Stack top for return
  output logic [14:0] pc_o, // Program counter
  output logic [7:0] rdata_o, // Read data
  output logic [11:0] addr_o, // Data address of last access
  output logic flush_o, // Discard prefetched instruction
  output logic push_o, // Push pc_o to stack
  output logic [14:0] push_data_o, // Address pushed
  output logic pop_o, // Pop stack on return
  output logic [7:0] working_register_o, // Working register
  output logic [7:0] status_o, // Status register
  output logic in_service_o // Inside service routine
);
  // ***************************************************************
  // State
  // ***************************************************************
  typedef enum logic [1:0] {
    PBC_RUN,
    PBC_ENTRY,
    PBC_VECTOR
  } pbc_state_t;

  pbc_state_t state_q, state_d;
  logic [14:0] pc_q, pc_d;
  logic [7:0] status_q, working_register_q, bank_q, latch_q, interrupt_control_q;
  logic [7:0] peripheral_enable_1_q, peripheral_flags_1_q;
  logic [15:0] ptr0_q, ptr1_q;
  logic [7:0] sh_status_q, sh_working_register_q, sh_bank_q, sh_latch_q;
  logic [15:0] sh_ptr0_q, sh_ptr1_q;
  logic [7:0] rdata_q;
  logic [11:0] addr_q;
  logic flush_q, push_q, pop_q, in_service_q;
  logic [14:0] push_data_q;
  logic [7:0] ram_q [pbc_pkg::NUM_BANKS][pbc_pkg::BANK_BYTES];

  // ***************************************************************
  // Address forming and register decode
  // ***************************************************************
  logic [11:0] acc_addr;
  logic acc_core;

  pbc_bank_decode i_pbc_bank_decode (
    .ind_i (dreq_i.ind),
    .ind_sel_i (dreq_i.ind_sel),
    .ofs_i (dreq_i.ofs),
    .bank_i (bank_q),
    .ptr0_i (ptr0_q),
    .ptr1_i (ptr1_q),
    .addr_o (acc_addr),
    .is_core_o (acc_core)
  );

  wire [6:0] acc_ofs = acc_addr[6:0];
  wire [4:0] acc_bank = acc_addr[11:7];

  function automatic logic hit(input logic [6:0] ofs,
                               input logic [6:0] which,
                               input logic wr);
    hit = wr && (ofs == which);
  endfunction

  // Offsets 0 and 1 read zero and ignore writes; indirect access comes from dreq_i.ind; a nested indirect
  // lands on offset 0 or 1 again, so it reads zero and its write is dropped.
  wire use_core = acc_core;
  wire is_ram = (acc_ofs >= pbc_pkg::OFS_GPR_FIRST);
  wire wr = dreq_i.wr && !flush_q;
  wire w_pcl = use_core && hit(acc_ofs,
    pbc_pkg::OFS_PROGRAM_COUNTER_LOW, wr);
  wire w_stat = use_core && hit(acc_ofs, pbc_pkg::OFS_CORE_STATUS, wr);
  wire w_p0l = use_core && hit(acc_ofs, pbc_pkg::OFS_POINTER0_LOW, wr);
  wire w_p0h = use_core && hit(acc_ofs, pbc_pkg::OFS_POINTER0_HIGH, wr);
  wire w_p1l = use_core && hit(acc_ofs, pbc_pkg::OFS_POINTER1_LOW, wr);
  wire w_p1h = use_core && hit(acc_ofs, pbc_pkg::OFS_POINTER1_HIGH, wr);
  wire w_bank = use_core && hit(acc_ofs, pbc_pkg::OFS_BANK_SELECT, wr);
  wire w_working_register = use_core &&
    hit(acc_ofs, pbc_pkg::OFS_WORKING_REGISTER, wr);
  wire w_latch = use_core &&
    hit(acc_ofs, pbc_pkg::OFS_COUNTER_HIGH_LATCH, wr);
  wire w_ic = use_core &&
    hit(acc_ofs, pbc_pkg::OFS_INTERRUPT_CONTROL, wr);
  wire w_pie = hit(acc_ofs, pbc_pkg::OFS_PERIPH_ENABLE_1, wr);
  wire w_pir = hit(acc_ofs, pbc_pkg::OFS_PERIPH_FLAGS_1, wr);
  wire w_ram = wr && is_ram;

  // ***************************************************************
  // Read data
  // ***************************************************************
  logic [7:0] rd_val;
  always_comb
  begin
    case (acc_ofs)
      pbc_pkg::OFS_PROGRAM_COUNTER_LOW: rd_val = pc_q[7:0];
      pbc_pkg::OFS_CORE_STATUS: rd_val = status_q;
      pbc_pkg::OFS_POINTER0_LOW: rd_val = ptr0_q[7:0];
      pbc_pkg::OFS_POINTER0_HIGH: rd_val = ptr0_q[15:8];
      pbc_pkg::OFS_POINTER1_LOW: rd_val = ptr1_q[7:0];
      pbc_pkg::OFS_POINTER1_HIGH: rd_val = ptr1_q[15:8];
      pbc_pkg::OFS_BANK_SELECT: rd_val = bank_q;
      pbc_pkg::OFS_WORKING_REGISTER: rd_val = working_register_q;
      pbc_pkg::OFS_COUNTER_HIGH_LATCH: rd_val = latch_q;
      pbc_pkg::OFS_INTERRUPT_CONTROL: rd_val = interrupt_control_q;
      pbc_pkg::OFS_PERIPH_ENABLE_1: rd_val = peripheral_enable_1_q;
      pbc_pkg::OFS_PERIPH_FLAGS_1: rd_val = peripheral_flags_1_q;
      default: rd_val = is_ram ? ram_q[acc_bank][acc_ofs] :
        pbc_pkg::RST_BYTE;
    endcase
  end

  // ***************************************************************
  // Interrupt qualification
  // ***************************************************************
  wire global_interrupt_enable = interrupt_control_q[pbc_pkg::IC_GLOBAL];
  wire peripheral_interrupt_enable = interrupt_control_q[pbc_pkg::IC_PERIPH];
  wire [2:0] core_en = interrupt_control_q[5:3];
  wire [2:0] core_fl = interrupt_control_q[2:0];
  wire core_pend = |(core_en & core_fl);
  wire periph_pend = peripheral_interrupt_enable && |(peripheral_enable_1_q & peripheral_flags_1_q);
  wire take_int = global_interrupt_enable && (core_pend || periph_pend) &&
    (state_q == PBC_RUN) && fetch_i;
  wire is_ret = cmd_i.valid && (cmd_i.op == pbc_pkg::PBC_OP_RETURN_INT);
  wire cmd_jump = cmd_i.valid && (cmd_i.op != pbc_pkg::PBC_OP_NONE);
  // Shadows restore on return; a same-cycle software write loses to it.
  // An interrupt taken in the same cycle wins, so nothing is popped.
  wire restore = is_ret && !flush_q && (state_q == PBC_RUN) &&
    !take_int;

  // ***************************************************************
  // Program counter
  // ***************************************************************
  logic [14:0] tgt_pc;
  pbc_pc_next i_pbc_pc_next (
    .op_i (cmd_i.op),
    .operand_i (cmd_i.operand),
    .ret_addr_i (cmd_i.ret_addr),
    .working_register_i (working_register_q),
    .latch_i (latch_q),
    .pop_i (stack_top_i),
    .pc_o (tgt_pc)
  );

  wire [14:0] pcl_pc = {latch_q[6:0], dreq_i.wdata};
  wire [14:0] inc_pc = pc_q + 15'h0001;

  always_comb
  begin
    state_d = state_q;
    pc_d = pc_q;
    case (state_q)
      PBC_RUN:
      begin
        if (take_int)
          state_d = PBC_ENTRY;
        else if (cmd_jump && !flush_q)
          pc_d = tgt_pc;
        else if (w_pcl)
          pc_d = pcl_pc;
        else if (fetch_i)
          pc_d = inc_pc;
      end
      PBC_ENTRY:
        state_d = PBC_VECTOR;
      PBC_VECTOR:
      begin
        pc_d = pbc_pkg::INT_VECTOR;
        state_d = PBC_RUN;
      end
      default: state_d = PBC_RUN;
    endcase
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q <= PBC_RUN;
      pc_q <= pbc_pkg::RST_PC;
      flush_q <= 1'b0;
      push_q <= 1'b0;
      pop_q <= 1'b0;
      push_data_q <= pbc_pkg::RST_PC;
      in_service_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pc_q <= pc_d;
      flush_q <= take_int;
      push_q <= take_int;
      push_data_q <= take_int ? pc_q : push_data_q;
      pop_q <= restore;
      in_service_q <= take_int ? 1'b1 :
        restore ? 1'b0 : in_service_q;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      status_q <= pbc_pkg::RST_BYTE;
      working_register_q <= pbc_pkg::RST_BYTE;
      bank_q <= pbc_pkg::RST_BYTE;
      latch_q <= pbc_pkg::RST_BYTE;
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
    end
    else if (restore)
    begin
      status_q <= sh_status_q;
      working_register_q <= sh_working_register_q;
      bank_q <= sh_bank_q;
      latch_q <= sh_latch_q;
      ptr0_q <= sh_ptr0_q;
      ptr1_q <= sh_ptr1_q;
    end
    else
    begin
      status_q <= w_stat ? dreq_i.wdata :
        status_we_i ? status_i : status_q;
      working_register_q <= w_working_register ? dreq_i.wdata : working_register_q;
      bank_q <= w_bank ? {3'h0, dreq_i.wdata[4:0]} : bank_q;
      latch_q <= w_latch ? {1'b0, dreq_i.wdata[6:0]} : latch_q;
      ptr0_q[7:0] <= w_p0l ? dreq_i.wdata : ptr0_q[7:0];
      ptr0_q[15:8] <= w_p0h ? dreq_i.wdata : ptr0_q[15:8];
      ptr1_q[7:0] <= w_p1l ? dreq_i.wdata : ptr1_q[7:0];
      ptr1_q[15:8] <= w_p1h ? dreq_i.wdata : ptr1_q[15:8];
    end
  end

  // Shadow copies are taken at entry.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sh_status_q <= pbc_pkg::RST_BYTE;
      sh_working_register_q <= pbc_pkg::RST_BYTE;
      sh_bank_q <= pbc_pkg::RST_BYTE;
      sh_latch_q <= pbc_pkg::RST_BYTE;
      sh_ptr0_q <= 16'h0000;
      sh_ptr1_q <= 16'h0000;
    end
    else if (take_int)
    begin
      sh_status_q <= status_q;
      sh_working_register_q <= working_register_q;
      sh_bank_q <= bank_q;
      sh_latch_q <= latch_q;
      sh_ptr0_q <= ptr0_q;
      sh_ptr1_q <= ptr1_q;
    end
  end

  // ***************************************************************
  // Interrupt control and flags
  // ***************************************************************
  // Flags: a hardware event wins over a software clear in the same cycle.
  wire [7:0] ic_sw = w_ic ? dreq_i.wdata : interrupt_control_q;
  wire [7:0] ic_flags = {5'h00, ic_sw[2:0] | core_evt_i};
  wire ic_gie = take_int ? 1'b0 : restore ? 1'b1 :
    ic_sw[pbc_pkg::IC_GLOBAL];
  wire [7:0] ic_next = {ic_gie, ic_sw[6:3], ic_flags[2:0]};
  wire [7:0] pir_next = (w_pir ? dreq_i.wdata : peripheral_flags_1_q) |
    periph_evt_i;

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      interrupt_control_q <= pbc_pkg::RST_BYTE;
      peripheral_enable_1_q <= pbc_pkg::RST_BYTE;
      peripheral_flags_1_q <= pbc_pkg::RST_BYTE;
    end
    else
    begin
      interrupt_control_q <= ic_next;
      peripheral_enable_1_q <= w_pie ? dreq_i.wdata : peripheral_enable_1_q;
      peripheral_flags_1_q <= pir_next;
    end
  end

  // ***************************************************************
  // Data RAM and read port
  // ***************************************************************
  // The RAM has no reset; contents are undefined until written.
  always_ff @(posedge core_clk_i)
  begin
    if (w_ram)
      ram_q[acc_bank][acc_ofs] <= dreq_i.wdata;
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rdata_q <= pbc_pkg::RST_BYTE;
      addr_q <= 12'h000;
    end
    else if (dreq_i.rd || dreq_i.wr)
    begin
      rdata_q <= dreq_i.rd ? rd_val : rdata_q;
      addr_q <= acc_addr;
    end
  end

  assign pc_o = pc_q;
  assign rdata_o = rdata_q;
  assign addr_o = addr_q;
  assign flush_o = flush_q;
  assign push_o = push_q;
  assign push_data_o = push_data_q;
  assign pop_o = pop_q;
  assign working_register_o = working_register_q;
  assign status_o = status_q;
  assign in_service_o = in_service_q;

endmodule

// ==== rtl/pbc_pkg.sv ====
// Package for the core sequencing block: register offsets, field
// positions, reset values, vector, opcodes of the sequencing commands.
// Assumes a single 200 MHz core clock and one asynchronous reset.
package pbc_pkg;

  // ***************************************************************
  // Memory geometry
  // ***************************************************************
  localparam int unsigned NUM_BANKS = 32;
  localparam int unsigned BANK_BYTES = 128;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BANK_W = 5;
  localparam int unsigned OFS_W = 7;
  localparam int unsigned PC_W = 15;
  localparam int unsigned CORE_REG_COUNT = 12;

  // ***************************************************************
  // Register offsets, mirrored in every bank, then offsets of the banked RAM
  // ***************************************************************
  localparam logic [6:0] OFS_INDIRECT_DATA_0 = 7'h00;
  localparam logic [6:0] OFS_INDIRECT_DATA_1 = 7'h01;
  localparam logic [6:0] OFS_PROGRAM_COUNTER_LOW = 7'h02;
  localparam logic [6:0] OFS_CORE_STATUS = 7'h03;
  localparam logic [6:0] OFS_POINTER0_LOW = 7'h04;
  localparam logic [6:0] OFS_POINTER0_HIGH = 7'h05;
  localparam logic [6:0] OFS_POINTER1_LOW = 7'h06;
  localparam logic [6:0] OFS_POINTER1_HIGH = 7'h07;
  localparam logic [6:0] OFS_BANK_SELECT = 7'h08;
  localparam logic [6:0] OFS_WORKING_REGISTER = 7'h09;
  localparam logic [6:0] OFS_COUNTER_HIGH_LATCH = 7'h0a;
  localparam logic [6:0] OFS_INTERRUPT_CONTROL = 7'h0b;
  localparam logic [6:0] OFS_PERIPH_ENABLE_1 = 7'h0c;
  localparam logic [6:0] OFS_PERIPH_FLAGS_1 = 7'h0d;
  localparam logic [6:0] OFS_GPR_FIRST = 7'h20;
  localparam logic [6:0] OFS_GPR_LAST = 7'h6f;
  localparam logic [6:0] OFS_COMMON_FIRST = 7'h70;

  // ***************************************************************
  // Interrupt control field positions
  // ***************************************************************
  localparam int unsigned IC_GLOBAL = 7;
  localparam int unsigned IC_PERIPH = 6;
  localparam logic [7:0] IC_ENABLE_MASK = 8'h38;
  localparam logic [7:0] IC_FLAG_MASK = 8'h07;

  // ***************************************************************
  // Reset values and vector
  // ***************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [14:0] RST_PC = 15'h0000;
  localparam logic [14:0] INT_VECTOR = 15'h0004;
  localparam logic [1:0] INT_ENTRY_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    PBC_OP_NONE,
    PBC_OP_CALL,
    PBC_OP_COMPUTED_CALL,
    PBC_OP_REG_BRANCH,
    PBC_OP_OPND_BRANCH,
    PBC_OP_RETURN_INT
  } pbc_op_t;

  // Data bus request from the execute stage.
  typedef struct packed {
    logic rd;
    logic wr;
    logic ind;
    logic ind_sel;
    logic [6:0] ofs;
    logic [7:0] wdata;
  } pbc_dreq_t;

  // Sequencing command from the decoder.
  typedef struct packed {
    logic valid;
    pbc_op_t op;
    logic [10:0] operand;
    logic [14:0] ret_addr;
  } pbc_cmd_t;

endpackage

// ==== rtl/pbc_bank_decode.sv ====
// Address former: builds the 12-bit data address from a direct operand
// and bank select, or from a pointer pair for indirect access.
// Assumes operands are stable for the cycle they are presented.
`timescale 1ns/1ps
module pbc_bank_decode (
  input wire logic ind_i, // Indirect access
  input wire logic ind_sel_i, // Pointer 1 when set
  input wire logic [6:0] ofs_i, // Direct offset
  input wire logic [7:0] bank_i, // Bank select value
  input wire logic [15:0] ptr0_i, // Pointer pair 0
  input wire logic [15:0] ptr1_i, // Pointer pair 1
  output logic [11:0] addr_o, // Full data address
  output logic is_core_o // Address hits a core register
);
  wire [15:0] ptr_sel = ind_sel_i ? ptr1_i : ptr0_i;
  wire [4:0] dir_bank = bank_i[4:0];
  wire [11:0] dir_addr = {dir_bank, ofs_i};
  // Pointers span the whole data space; only the low 12 bits matter.
  assign addr_o = ind_i ? ptr_sel[11:0] : dir_addr;
  assign is_core_o = (addr_o[6:0] <
    7'(pbc_pkg::CORE_REG_COUNT));
endmodule

// ==== rtl/pbc_pc_next.sv ====
// Next program counter selection for calls, computed calls, branches and
// return. Assumes ret_addr_i is the address of the following word.
`timescale 1ns/1ps
module pbc_pc_next (
  input wire pbc_pkg::pbc_op_t op_i, // Sequencing command
  input wire logic [10:0] operand_i, // Instruction operand
  input wire logic [14:0] ret_addr_i, // Branch address plus one
  input wire logic [7:0] working_register_i, // Working register
  input wire logic [7:0] latch_i, // Counter high latch
  input wire logic [14:0] pop_i, // Top of stack
  output logic [14:0] pc_o // Target counter
);
  wire [14:0] call_pc = {latch_i[6:3], operand_i};
  wire [14:0] ccall_pc = {latch_i[6:0], working_register_i};
  wire [14:0] wbr_pc = ret_addr_i + {7'h00, working_register_i};
  wire [14:0] sext = {{6{operand_i[8]}}, operand_i[8:0]};
  wire [14:0] abr_pc = ret_addr_i + sext;

  always_comb
  begin
    case (op_i)
      pbc_pkg::PBC_OP_CALL: pc_o = call_pc;
      pbc_pkg::PBC_OP_COMPUTED_CALL: pc_o = ccall_pc;
      pbc_pkg::PBC_OP_REG_BRANCH: pc_o = wbr_pc;
      pbc_pkg::PBC_OP_OPND_BRANCH: pc_o = abr_pc;
      pbc_pkg::PBC_OP_RETURN_INT: pc_o = pop_i;
      default: pc_o = ret_addr_i;
    endcase
  end
endmodule

// ==== tb/pbc_core_sva.sv ====
// Assertions on the ports of the core sequencing block.
// Assumes one core clock and the active-high asynchronous reset.
`timescale 1ns/1ps
module pbc_core_sva (
  input wire logic core_clk_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic fetch_i, // Fetch
  input wire pbc_pkg::pbc_cmd_t cmd_i, // Command
  input wire pbc_pkg::pbc_dreq_t dreq_i, // Data request
  input wire logic [14:0] stack_top_i, // Stack top
  input wire logic [14:0] pc_o, // Counter
  input wire logic [7:0] rdata_o, // Read data
  input wire logic flush_o, // Flush
  input wire logic push_o, // Push
  input wire logic pop_o, // Pop
  input wire logic [7:0] working_register_o // W
);
  // *****
  // Helpers
  // *****
  // Commands are dropped in the two entry cycles, so checks skip them.
  logic ent_q;
  wire no_seq = !fetch_i && !flush_o && !ent_q;
  wire cmd_ok = cmd_i.valid && no_seq && !dreq_i.wr;
  wire rd_dir = dreq_i.rd && !dreq_i.wr && !dreq_i.ind;
  wire [14:0] w_ext = {7'h00, working_register_o};
  wire [14:0] op_sx = {{6{cmd_i.operand[8]}}, cmd_i.operand[8:0]};
  always_ff @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
      ent_q <= 1'b0;
    else
      ent_q <= flush_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_vector;
    flush_o |-> push_o ##2 pc_o == pbc_pkg::INT_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("bad entry");
  property p_ret;
    pop_o |-> pc_o == $past(stack_top_i);
  endproperty
  a_ret: assert property (p_ret) else $error("bad return");
  property p_fetch;
    fetch_i && !cmd_i.valid && !dreq_i.wr && !flush_o && !ent_q
      |=> flush_o || pc_o == $past(pc_o) + 15'h0001;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no advance");
  property p_pcl;
    dreq_i.wr && !dreq_i.ind && !cmd_i.valid && no_seq &&
      dreq_i.ofs == pbc_pkg::OFS_PROGRAM_COUNTER_LOW
      |=> pc_o[7:0] == $past(dreq_i.wdata);
  endproperty
  a_pcl: assert property (p_pcl) else $error("bad pc write");
  property p_wread;
    rd_dir && dreq_i.ofs == pbc_pkg::OFS_WORKING_REGISTER
      |=> rdata_o == $past(working_register_o);
  endproperty
  a_wread: assert property (p_wread) else $error("bad w read");
  property p_zero;
    rd_dir && dreq_i.ofs == 7'h10 |=> rdata_o == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("nonzero read");
  property p_call;
    cmd_ok && cmd_i.op == pbc_pkg::PBC_OP_CALL
      |=> pc_o[10:0] == $past(cmd_i.operand);
  endproperty
  a_call: assert property (p_call) else $error("bad call");
  property p_ccall;
    cmd_ok && cmd_i.op == pbc_pkg::PBC_OP_COMPUTED_CALL
      |=> pc_o[7:0] == $past(working_register_o);
  endproperty
  a_ccall: assert property (p_ccall) else $error("bad w call");
  property p_wbr;
    cmd_ok && cmd_i.op == pbc_pkg::PBC_OP_REG_BRANCH
      |=> pc_o == $past(cmd_i.ret_addr) + $past(w_ext);
  endproperty
  a_wbr: assert property (p_wbr) else $error("bad w branch");
  property p_obr;
    cmd_ok && cmd_i.op == pbc_pkg::PBC_OP_OPND_BRANCH
      |=> pc_o == $past(cmd_i.ret_addr) + $past(op_sx);
  endproperty
  a_obr: assert property (p_obr) else $error("bad branch");
  c_entry: cover property (flush_o);
  c_return: cover property (pop_o);
  c_branch: cover property (cmd_ok && cmd_i.op[2]);
endmodule
bind pbc_core pbc_core_sva i_pbc_core_sva (.core_clk_i(core_clk_i),
  .reset_i(reset_i), .fetch_i(fetch_i), .cmd_i(cmd_i), .dreq_i(dreq_i),
  .stack_top_i(stack_top_i), .pc_o(pc_o), .rdata_o(rdata_o),
  .flush_o(flush_o), .push_o(push_o), .pop_o(pop_o), .working_register_o(working_register_o));

// ==== tb/pbc_far_model.sv ====
// Far side: fetch strobes and a one-deep return stack.
// Assumes the bench changes its enables at falling edges.
`timescale 1ns/1ps
module pbc_far_model (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic fetch_en_i, // Fetch when set
  input wire logic slow_i, // Fetch every other cycle
  input wire logic push_i, // Push strobe
  input wire logic [14:0] push_data_i, // Address pushed
  output logic fetch_o, // Fetch strobe
  output logic [14:0] stack_top_o // Stack top
);
  // One level only: the bench never nests service routines.
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
      fetch_o <= 1'b0;
    else
      fetch_o <= fetch_en_i && !(slow_i && fetch_o);
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
      stack_top_o <= 15'h7fff;
    else if (push_i)
      stack_top_o <= push_data_i;
endmodule

// ==== tb/pbc_core_bench.sv ====
// Self-checking bench for the core sequencing block.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ps
module pbc_core_bench;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic fetch_en = 1'b0;
  logic slow = 1'b0;
  logic fetch_i, push_o, pop_o, flush_o, in_service_o;
  pbc_pkg::pbc_cmd_t cmd_i = '0;
  pbc_pkg::pbc_dreq_t dreq_i = '0;
  logic [7:0] periph_evt_i = 8'h00;
  logic [2:0] core_evt_i = 3'h0;
  logic [14:0] stack_top_i, pc_o, push_data_o, pre;
  logic [7:0] rdata_o, working_register_o, status_o, rd_v;
  logic [11:0] addr_o;
  int bad_count = 0;
  int check_count = 0;
  int flush_n = 0;
  always #2.5 core_clk_i = !core_clk_i;
  always @(negedge core_clk_i)
    if (flush_o === 1'b1)
      flush_n++;
  pbc_core i_pbc_core (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .fetch_i(fetch_i), .cmd_i(cmd_i), .dreq_i(dreq_i), .status_i(8'h00),
    .status_we_i(1'b0), .core_evt_i(core_evt_i),
    .periph_evt_i(periph_evt_i),
    .stack_top_i(stack_top_i), .pc_o(pc_o), .rdata_o(rdata_o),
    .addr_o(addr_o), .flush_o(flush_o), .push_o(push_o),
    .push_data_o(push_data_o), .pop_o(pop_o), .working_register_o(working_register_o),
    .status_o(status_o), .in_service_o(in_service_o));
  pbc_far_model i_pbc_far_model (.clk_i(core_clk_i), .reset_i(reset_i),
    .fetch_en_i(fetch_en), .slow_i(slow), .push_i(push_o),
    .push_data_i(push_data_o), .fetch_o(fetch_i),
    .stack_top_o(stack_top_i));
  task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic go(pbc_pkg::pbc_dreq_t r);
    @(negedge core_clk_i);
    dreq_i = r;
    @(negedge core_clk_i);
    dreq_i = '0;
    rd_v = rdata_o;
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    go('{1'b0, 1'b1, 1'b0, 1'b0, a, d});
  endtask
  task automatic rd(logic [6:0] a, logic i = 1'b0, logic s = 1'b0);
    go('{1'b1, 1'b0, i, s, a, 8'h00});
  endtask
  task automatic cmd(pbc_pkg::pbc_op_t op, logic [10:0] opnd);
    @(negedge core_clk_i);
    cmd_i = '{1'b1, op, opnd, 15'h1234};
    @(negedge core_clk_i);
    cmd_i = '0;
  endtask
  task automatic end_sim();
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_bank();
    chk("pc reset", 16'(pc_o), 16'h0000);
    rd(7'h0b);
    chk("int reset", 16'(rd_v), 16'h0000);
    wr(7'h08, 8'h05);
    wr(7'h20, 8'ha5);
    wr(7'h08, 8'h1f);
    wr(7'h20, 8'h3c);
    wr(7'h09, 8'h77);
    chk("addr", 16'(addr_o), 16'h0f89);
    wr(7'h08, 8'h05);
    rd(7'h20);
    chk("bank gpr", 16'(rd_v), 16'h00a5);
    rd(7'h09);
    chk("mirror w", 16'(rd_v), 16'h0077);
    rd(7'h10);
    chk("unimpl", 16'(rd_v), 16'h0000);
    wr(7'h06, 8'ha0);
    wr(7'h07, 8'h0f);
    rd(7'h00, 1'b1, 1'b1);
    chk("pointer 1", 16'(rd_v), 16'h003c);
    wr(7'h04, 8'ha0);
    wr(7'h05, 8'h02);
    rd(7'h00, 1'b1, 1'b0);
    chk("pointer 0", 16'(rd_v), 16'h00a5);
  endtask
  task automatic t_pc();
    wr(7'h0a, 8'h15);
    wr(7'h02, 8'h3c);
    chk("pc write", 16'(pc_o), 16'h153c);
    rd(7'h02);
    chk("pc low", 16'(rd_v), 16'h003c);
    fetch_en = 1'b1;
    repeat (3) @(negedge core_clk_i);
    fetch_en = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk("advance", 16'(pc_o), 16'h153f);
    wr(7'h0a, 8'h7f);
    wr(7'h09, 8'hff);
    cmd(pbc_pkg::PBC_OP_CALL, 11'h5a5);
    chk("call", 16'(pc_o), 16'h7da5);
    cmd(pbc_pkg::PBC_OP_COMPUTED_CALL, 11'h000);
    chk("w call", 16'(pc_o), 16'h7fff);
    cmd(pbc_pkg::PBC_OP_REG_BRANCH, 11'h000);
    chk("w branch", 16'(pc_o), 16'h1333);
    cmd(pbc_pkg::PBC_OP_OPND_BRANCH, 11'h1fe);
    chk("branch back", 16'(pc_o), 16'h1232);
    cmd(pbc_pkg::PBC_OP_OPND_BRANCH, 11'h0ff);
    chk("branch fwd", 16'(pc_o), 16'h1333);
  endtask
  task automatic t_int();
    core_evt_i = 3'h4;
    @(negedge core_clk_i);
    core_evt_i = 3'h0;
    rd(7'h0b);
    chk("core flag", 16'(rd_v), 16'h0004);
    wr(7'h0b, 8'h00);
    wr(7'h03, 8'h5a);
    chk("status", 16'(status_o), 16'h005a);
    wr(7'h0c, 8'h01);
    periph_evt_i = 8'h01;
    @(negedge core_clk_i);
    periph_evt_i = 8'h00;
    fetch_en = 1'b1;
    slow = 1'b1;
    rd(7'h0d);
    chk("flag", 16'(rd_v), 16'h0001);
    wr(7'h0b, 8'h80);
    repeat (6) @(negedge core_clk_i);
    chk("no entry", flush_n[15:0], 16'h0000);
    wr(7'h0b, 8'hc0);
    pre = pc_o;
    for (int i = 0; i < 10 && flush_o !== 1'b1; i++)
    begin
      pre = pc_o;
      @(negedge core_clk_i);
    end
    chk("entry", 16'(flush_o), 16'h0001);
    chk("pushed", 16'(push_data_o), 16'(pre));
    repeat (2) @(negedge core_clk_i);
    chk("vector", 16'(pc_o), 16'h0004);
    fetch_en = 1'b0;
    chk("in service", 16'(in_service_o), 16'h0001);
    rd(7'h0b);
    chk("global off", 16'(rd_v), 16'h0040);
    wr(7'h09, 8'h00);
    wr(7'h03, 8'h00);
    wr(7'h0d, 8'h00);
    cmd(pbc_pkg::PBC_OP_RETURN_INT, 11'h000);
    chk("return pc", 16'(pc_o), 16'(pre));
    chk("w restored", 16'(working_register_o), 16'h00ff);
    chk("status restored", 16'(status_o), 16'h005a);
    rd(7'h0b);
    chk("global on", 16'(rd_v), 16'h00c0);
  endtask
  initial
  begin
    repeat (6) @(negedge core_clk_i);
    reset_i = 1'b0;
    t_bank();
    t_pc();
    t_int();
    end_sim();
  end
  initial
  begin
    #20000;
    bad_count++;
    end_sim();
  end
endmodule
